// ===== hdl/wcs_pkg.sv
package wcs_pkg;

    // Register offsets
    localparam logic [6:0] ADDR_WAKE_PULL = 7'h08;
    localparam logic [6:0] ADDR_WAKE_FILTER = 7'h09;
    localparam logic [6:0] ADDR_TIMER_A = 7'h0c;

    // Reset values
    localparam logic [7:0] RST_WAKE_PULL = 8'h00;
    localparam logic [7:0] RST_WAKE_FILTER = 8'h00;
    localparam logic [7:0] RST_TIMER_A = 8'h00;

    // Writable bit masks, reserved bits excluded
    localparam logic [7:0] MASK_WAKE = 8'h3f;
    localparam logic [7:0] MASK_TIMER = 8'h77;

    // Field width and positions
    localparam int WAKE_FIELD_W = 2;
    localparam int ON_LSB = 4;
    localparam int PER_LSB = 0;

    // Pull selection codes
    localparam logic [1:0] PULL_NONE = 2'h0;
    localparam logic [1:0] PULL_DOWN = 2'h1;
    localparam logic [1:0] PULL_UP = 2'h2;
    localparam logic [1:0] PULL_AUTO = 2'h3;

    // Filter selection codes
    localparam logic [1:0] FLT_STATIC_SHORT = 2'h0;
    localparam logic [1:0] FLT_STATIC_LONG = 2'h1;
    localparam logic [1:0] FLT_CYCLIC_A = 2'h2;
    localparam logic [1:0] FLT_CYCLIC_B = 2'h3;

    // On-time stop codes
    localparam logic [2:0] ON_STOP_LOW = 3'h0;
    localparam logic [2:0] ON_STOP_HIGH = 3'h6;
    localparam logic [2:0] CODE_RESERVED = 3'h7;

    // Switch configuration codes
    localparam logic [2:0] HS_BY_TIMER_A = 3'h2;
    localparam logic [2:0] HS_BY_TIMER_B = 3'h3;

    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_TIME_NS = 100000;
    localparam int FLT_SHORT_NS = 16000;
    localparam int FLT_LONG_NS = 64000;
    localparam int TICK_CYCLES = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLT_SHORT_CYCLES = (FLT_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLT_LONG_CYCLES = (FLT_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Register access request from the serial frame decoder
    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } wcs_reg_req_t;

endpackage : wcs_pkg

// ===== hdl/wcs_wake_cyclic.sv
`timescale 1ns/1ns
module wcs_wake_cyclic #(
    parameter int TICK_CYCLES = wcs_pkg::TICK_CYCLES,
    parameter int FLT_LONG_CYCLES = wcs_pkg::FLT_LONG_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register access
    input wire wcs_pkg::wcs_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    // Device state
    input wire logic soft_reset,
    input wire logic restart_state,
    input wire logic hs_clear,
    input wire logic measure_function_select,
    input wire logic [2:0] wake_enable,
    input wire logic [1:0] timer_wake_enable,
    input wire logic [7:0] timer_b_config,
    input wire logic [11:0] hs_config,
    // Wake pins
    input wire logic [2:0] wake_pin,
    output logic [2:0] wake_pull_up,
    output logic [2:0] wake_pull_down,
    output logic [2:0] wake_level,
    output logic [2:0] wake_event,
    // Timers and switches
    output logic [1:0] timer_out,
    output logic [1:0] timer_wake_event,
    output logic [3:0] hs_timer_drive,
    output logic [3:0] high_side_switch_output
);

    generate
        if (TICK_CYCLES < 2 || TICK_CYCLES > 65535) begin : g_bad_tick
            $error("TICK_CYCLES out of range");
        end
        if (FLT_LONG_CYCLES < 2 || FLT_LONG_CYCLES > 8191) begin : g_bad_flt
            $error("FLT_LONG_CYCLES out of range");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Encoding functions

    function automatic logic [14:0] on_ticks(input logic [2:0] code);
        case (code)
            3'h1: on_ticks = 15'h0001;
            3'h2: on_ticks = 15'h0003;
            3'h3: on_ticks = 15'h000a;
            3'h4: on_ticks = 15'h0064;
            3'h5: on_ticks = 15'h00c8;
            default: on_ticks = 15'h0000;
        endcase
    endfunction : on_ticks

    function automatic logic [14:0] per_ticks(input logic [2:0] code);
        case (code)
            3'h0: per_ticks = 15'h0064;
            3'h1: per_ticks = 15'h00c8;
            3'h2: per_ticks = 15'h01f4;
            3'h3: per_ticks = 15'h03e8;
            3'h4: per_ticks = 15'h07d0;
            3'h5: per_ticks = 15'h2710;
            3'h6: per_ticks = 15'h4e20;
            default: per_ticks = 15'h0000;
        endcase
    endfunction : per_ticks

    function automatic logic timer_running(input logic [7:0] cfg);
        logic [2:0] on_code;
        logic [2:0] per_code;
        on_code = cfg[wcs_pkg::ON_LSB +: 3];
        per_code = cfg[wcs_pkg::PER_LSB +: 3];
        timer_running = (on_code != wcs_pkg::ON_STOP_LOW) && (on_code != wcs_pkg::ON_STOP_HIGH)
            && (on_code != wcs_pkg::CODE_RESERVED)
            && (per_code != wcs_pkg::CODE_RESERVED);
    endfunction : timer_running

    function automatic logic is_cyclic(input logic [1:0] f);
        is_cyclic = (f == wcs_pkg::FLT_CYCLIC_A) || (f == wcs_pkg::FLT_CYCLIC_B);
    endfunction : is_cyclic

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0] pull_reg;
    logic [7:0] filter_reg;
    logic [7:0] timer_a_reg;
    logic cyclic_in_use;

    assign cyclic_in_use = is_cyclic(filter_reg[1:0]) || is_cyclic(filter_reg[3:2])
        || is_cyclic(filter_reg[5:4]);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pull_reg <= wcs_pkg::RST_WAKE_PULL;
        end else if (soft_reset) begin
            pull_reg <= wcs_pkg::RST_WAKE_PULL;
        end else if (reg_req.wr && reg_req.addr == wcs_pkg::ADDR_WAKE_PULL) begin
            pull_reg <= reg_req.wdata & wcs_pkg::MASK_WAKE;
        end
    end

    // Restart does not touch this register, so its settings survive restart entry
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            filter_reg <= wcs_pkg::RST_WAKE_FILTER;
        end else if (soft_reset) begin
            filter_reg <= wcs_pkg::RST_WAKE_FILTER;
        end else if (reg_req.wr && reg_req.addr == wcs_pkg::ADDR_WAKE_FILTER) begin
            filter_reg <= reg_req.wdata & wcs_pkg::MASK_WAKE;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            timer_a_reg <= wcs_pkg::RST_TIMER_A;
        end else if (soft_reset) begin
            timer_a_reg <= wcs_pkg::RST_TIMER_A;
        end else if (restart_state && hs_clear && cyclic_in_use) begin
            timer_a_reg <= 8'h00;
        end else if (reg_req.wr && reg_req.addr == wcs_pkg::ADDR_TIMER_A) begin
            timer_a_reg <= reg_req.wdata & wcs_pkg::MASK_TIMER;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_req.rd) begin
            case (reg_req.addr)
                wcs_pkg::ADDR_WAKE_PULL: reg_rdata <= pull_reg;
                wcs_pkg::ADDR_WAKE_FILTER: reg_rdata <= filter_reg;
                wcs_pkg::ADDR_TIMER_A: reg_rdata <= timer_a_reg;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Time base, one tick per 0.1 ms

    logic [15:0] presc_reg;
    logic tick_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            presc_reg <= 16'h0000;
            tick_reg <= 1'b0;
        end else if (presc_reg == 16'(TICK_CYCLES - 1)) begin
            presc_reg <= 16'h0000;
            tick_reg <= 1'b1;
        end else begin
            presc_reg <= presc_reg + 16'h0001;
            tick_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cyclic timers A and B

    logic [7:0] timer_cfg [2];
    logic [1:0] on_end;

    assign timer_cfg[0] = timer_a_reg;
    assign timer_cfg[1] = timer_b_config & wcs_pkg::MASK_TIMER;

    genvar t;
    generate
        for (t = 0; t < 2; t++) begin : g_timer
            logic [7:0] prev_cfg_reg;
            logic [14:0] cnt_reg;
            logic [14:0] on_len;
            logic [14:0] per_len;
            logic run;
            logic restart_cnt;
            logic on_end_reg;

            assign on_len = on_ticks(timer_cfg[t][wcs_pkg::ON_LSB +: 3]);
            assign per_len = per_ticks(timer_cfg[t][wcs_pkg::PER_LSB +: 3]);
            assign run = timer_running(timer_cfg[t]);
            assign restart_cnt = timer_cfg[t] != prev_cfg_reg;
            assign on_end[t] = on_end_reg;

            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    prev_cfg_reg <= 8'h00;
                end else begin
                    prev_cfg_reg <= timer_cfg[t];
                end
            end

            // A running code that differs from the previous cycle's config starts a fresh period
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    cnt_reg <= 15'h0000;
                    timer_out[t] <= 1'b0;
                    on_end_reg <= 1'b0;
                    timer_wake_event[t] <= 1'b0;
                end else if (!run) begin
                    cnt_reg <= 15'h0000;
                    timer_out[t] <= timer_cfg[t][wcs_pkg::ON_LSB +: 3]
                        == wcs_pkg::ON_STOP_HIGH;
                    on_end_reg <= 1'b0;
                    timer_wake_event[t] <= 1'b0;
                end else if (restart_cnt) begin
                    cnt_reg <= 15'h0000;
                    timer_out[t] <= 1'b1;
                    on_end_reg <= 1'b0;
                    timer_wake_event[t] <= 1'b0;
                end else if (tick_reg) begin
                    if (cnt_reg == per_len - 15'h0001) begin
                        cnt_reg <= 15'h0000;
                        timer_out[t] <= 1'b1;
                        on_end_reg <= on_len >= per_len;
                        timer_wake_event[t] <= timer_wake_enable[t];
                    end else begin
                        cnt_reg <= cnt_reg + 15'h0001;
                        if (cnt_reg + 15'h0001 == on_len) begin
                            timer_out[t] <= 1'b0;
                            on_end_reg <= 1'b1;
                        end else begin
                            on_end_reg <= 1'b0;
                        end
                        timer_wake_event[t] <= 1'b0;
                    end
                end else begin
                    on_end_reg <= 1'b0;
                    timer_wake_event[t] <= 1'b0;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Switch drive from the timers

    genvar h;
    generate
        for (h = 0; h < 4; h++) begin : g_hs
            logic [2:0] code;
            assign code = hs_config[h*3 +: 3];

            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    hs_timer_drive[h] <= 1'b0;
                    high_side_switch_output[h] <= 1'b0;
                end else if (code == wcs_pkg::HS_BY_TIMER_A) begin
                    hs_timer_drive[h] <= 1'b1;
                    high_side_switch_output[h] <= timer_out[0];
                end else if (code == wcs_pkg::HS_BY_TIMER_B) begin
                    hs_timer_drive[h] <= 1'b1;
                    high_side_switch_output[h] <= timer_out[1];
                end else begin
                    hs_timer_drive[h] <= 1'b0;
                    high_side_switch_output[h] <= 1'b0;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Wake input filters and pull control

    genvar w;
    generate
        for (w = 0; w < 3; w++) begin : g_wake
            logic sync1_reg;
            logic sync2_reg;
            logic [12:0] stab_reg;
            logic [1:0] flt;
            logic [1:0] pull;
            logic [12:0] limit;
            logic cyc;
            logic cyc_on;
            logic cyc_end;
            logic src_ok;

            assign flt = filter_reg[w*wcs_pkg::WAKE_FIELD_W +: wcs_pkg::WAKE_FIELD_W];
            assign pull = pull_reg[w*wcs_pkg::WAKE_FIELD_W +: wcs_pkg::WAKE_FIELD_W];
            assign limit = (flt == wcs_pkg::FLT_STATIC_LONG) ? 13'(FLT_LONG_CYCLES)
                : 13'(wcs_pkg::FLT_SHORT_CYCLES);
            assign cyc = is_cyclic(flt);
            assign cyc_on = (flt == wcs_pkg::FLT_CYCLIC_B) ? timer_out[1]
                : timer_out[0];
            assign cyc_end = (flt == wcs_pkg::FLT_CYCLIC_B) ? on_end[1] : on_end[0];
            assign src_ok = wake_enable[w] && !(measure_function_select && w < 2);

            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    sync1_reg <= 1'b0;
                    sync2_reg <= 1'b0;
                end else begin
                    sync1_reg <= wake_pin[w];
                    sync2_reg <= sync1_reg;
                end
            end

            // Counts how long the new level has held; any return clears it
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    stab_reg <= 13'h0000;
                    wake_level[w] <= 1'b0;
                    wake_event[w] <= 1'b0;
                end else if (sync2_reg == wake_level[w] || (cyc && !cyc_on && !cyc_end)) begin
                    stab_reg <= 13'h0000;
                    wake_event[w] <= 1'b0;
                end else if (cyc) begin
                    if (cyc_end && stab_reg >= limit) begin
                        stab_reg <= 13'h0000;
                        wake_level[w] <= sync2_reg;
                        wake_event[w] <= src_ok;
                    end else begin
                        stab_reg <= cyc_end ? 13'h0000
                            : (stab_reg >= limit ? stab_reg : stab_reg + 13'h0001);
                        wake_event[w] <= 1'b0;
                    end
                end else if (stab_reg == limit - 13'h0001) begin
                    stab_reg <= 13'h0000;
                    wake_level[w] <= sync2_reg;
                    wake_event[w] <= src_ok;
                end else begin
                    stab_reg <= stab_reg + 13'h0001;
                    wake_event[w] <= 1'b0;
                end
            end

            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    wake_pull_up[w] <= 1'b0;
                    wake_pull_down[w] <= 1'b0;
                end else begin
                    case (pull)
                        wcs_pkg::PULL_NONE: begin
                            wake_pull_up[w] <= 1'b0;
                            wake_pull_down[w] <= 1'b0;
                        end
                        wcs_pkg::PULL_DOWN: begin
                            wake_pull_up[w] <= 1'b0;
                            wake_pull_down[w] <= 1'b1;
                        end
                        wcs_pkg::PULL_UP: begin
                            wake_pull_up[w] <= 1'b1;
                            wake_pull_down[w] <= 1'b0;
                        end
                        default: begin
                            wake_pull_up[w] <= wake_level[w];
                            wake_pull_down[w] <= !wake_level[w];
                        end
                    endcase
                end
            end
        end
    endgenerate

endmodule : wcs_wake_cyclic

// ===== verif/wcs_wake_cyclic_sva.sv
`timescale 1ns/1ns
module wcs_wake_cyclic_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register access
    input wire wcs_pkg::wcs_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    // Device state
    input wire logic soft_reset,
    input wire logic restart_state,
    input wire logic hs_clear,
    input wire logic measure_function_select,
    input wire logic [11:0] hs_config,
    // Observed pin and outputs
    input wire logic [2:0] wake_pin,
    input wire logic [2:0] wake_pull_up,
    input wire logic [2:0] wake_pull_down,
    input wire logic [2:0] wake_level,
    input wire logic [2:0] wake_event,
    input wire logic [1:0] timer_out,
    input wire logic [3:0] hs_timer_drive
);
////////////////////////////////////////
logic [7:0] pull_sh, flt_sh, tmr_sh, exp_rd;
logic [6:0] addr_q;
logic rd_q;
logic [1:0] up_cnt;
logic [11:0] hi_cnt;

// Shadow registers
always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        {pull_sh, flt_sh, tmr_sh} <= 24'h000000;
    end else if (soft_reset) begin
        {pull_sh, flt_sh, tmr_sh} <= 24'h000000;
    end else begin
        if (reg_req.wr && reg_req.addr == wcs_pkg::ADDR_WAKE_PULL) begin
            pull_sh <= reg_req.wdata & wcs_pkg::MASK_WAKE;
        end
        if (reg_req.wr && reg_req.addr == wcs_pkg::ADDR_WAKE_FILTER) begin
            flt_sh <= reg_req.wdata & wcs_pkg::MASK_WAKE;
        end
        if (restart_state && hs_clear && (flt_sh[1] || flt_sh[3] || flt_sh[5])) begin
            tmr_sh <= 8'h00;
        end else if (reg_req.wr && reg_req.addr == wcs_pkg::ADDR_TIMER_A) begin
            tmr_sh <= reg_req.wdata & wcs_pkg::MASK_TIMER;
        end
    end
end

// Read tracking, settle counter, pin high time
always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        rd_q <= 1'b0;
        addr_q <= 7'h00;
        up_cnt <= 2'h0;
        hi_cnt <= 12'h000;
    end else begin
        rd_q <= reg_req.rd;
        addr_q <= reg_req.addr;
        up_cnt <= (up_cnt == 2'h3) ? up_cnt : up_cnt + 2'h1;
        hi_cnt <= !wake_pin[0] ? 12'h000 : (hi_cnt == 12'hfff) ? hi_cnt : hi_cnt + 12'h001;
    end
end

always_comb begin
    case (addr_q)
        wcs_pkg::ADDR_WAKE_PULL: exp_rd = pull_sh;
        wcs_pkg::ADDR_WAKE_FILTER: exp_rd = flt_sh;
        wcs_pkg::ADDR_TIMER_A: exp_rd = tmr_sh;
        default: exp_rd = 8'h00;
    endcase
end
////////////////////////////////////////
default clocking cb @(posedge clk); endclocking
default disable iff (!resetn || up_cnt != 2'h3);

a_read_value: assert property (rd_q |-> reg_rdata == exp_rd)
    else $error("read data differs from register contents");
a_pull_code: assert property ($stable(pull_sh) && pull_sh == $past(pull_sh, 2)
    && pull_sh[1:0] != wcs_pkg::PULL_AUTO
    |-> wake_pull_down[0] == (pull_sh[1:0] == wcs_pkg::PULL_DOWN)
    && wake_pull_up[0] == (pull_sh[1:0] == wcs_pkg::PULL_UP))
    else $error("pull outputs do not match pull code");
a_pull_auto: assert property ($stable(pull_sh) && pull_sh == $past(pull_sh, 2)
    && pull_sh[5:4] == wcs_pkg::PULL_AUTO && $stable(wake_level[2])
    |-> wake_pull_up[2] == wake_level[2] && wake_pull_down[2] == !wake_level[2])
    else $error("automatic pull does not follow level");
a_stop_low: assert property ($stable(tmr_sh) && tmr_sh == $past(tmr_sh, 2)
    && (tmr_sh[6:4] == 3'h0 || tmr_sh[6:4] == 3'h7
    || (tmr_sh[2:0] == 3'h7 && tmr_sh[6:4] != 3'h6)) |-> !timer_out[0])
    else $error("stopped timer output not low");
a_stop_high: assert property ($stable(tmr_sh) && tmr_sh == $past(tmr_sh, 2)
    && tmr_sh[6:4] == 3'h6 && tmr_sh[2:0] != 3'h7 |-> timer_out[0])
    else $error("stopped high timer output not high");
a_switch_drive: assert property ($stable(hs_config[2:0]) |-> hs_timer_drive[0] ==
    (hs_config[2:0] == wcs_pkg::HS_BY_TIMER_A || hs_config[2:0] == wcs_pkg::HS_BY_TIMER_B))
    else $error("switch timer drive does not match code");
a_event_pulse: assert property (wake_event[0] |=> !wake_event[0])
    else $error("wake event longer than one cycle");
a_event_level: assert property (wake_event[0] |-> wake_level[0] != $past(wake_level[0]))
    else $error("wake event without level change");
a_meas_block: assert property (measure_function_select
    && $past(measure_function_select) |-> wake_event[1:0] == 2'h0)
    else $error("wake event on blocked input");
a_filter_min: assert property ($rose(wake_level[0]) |-> hi_cnt >= 12'h640)
    else $error("level accepted before filter time");
endmodule : wcs_wake_cyclic_sva

bind wcs_wake_cyclic wcs_wake_cyclic_sva i_wcs_wake_cyclic_sva (
    .clk(clk), .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .soft_reset(soft_reset), .restart_state(restart_state), .hs_clear(hs_clear),
    .measure_function_select(measure_function_select), .hs_config(hs_config),
    .wake_pin(wake_pin), .wake_pull_up(wake_pull_up), .wake_pull_down(wake_pull_down),
    .wake_level(wake_level), .wake_event(wake_event), .timer_out(timer_out),
    .hs_timer_drive(hs_timer_drive));

// ===== verif/wcs_host.sv
`timescale 1ns/1ns
module wcs_host (
    // Clock
    input wire logic clk,
    // Register bus
    output wcs_pkg::wcs_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata
);
////////////////////////////////////////
initial begin
    reg_req = '0;
end

// Write: held through the taking edge, then released with scrambled fields
task automatic write_reg(input logic [6:0] addr, input logic [7:0] data);
    @(posedge clk);
    #1;
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge clk);
    #1;
    reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
endtask : write_reg

// Read: data taken one cycle after the taking edge
task automatic read_reg(input logic [6:0] addr, output logic [7:0] data);
    @(posedge clk);
    #1;
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge clk);
    #1;
    reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 8'hff};
    @(posedge clk);
    #1;
    data = reg_rdata;
endtask : read_reg
endmodule : wcs_host

// ===== verif/tb_wcs_wake_cyclic.sv
`timescale 1ns/1ns
module tb_wcs_wake_cyclic;
localparam int TICK = 10;
logic clk = 1'b0;
logic resetn = 1'b0;
logic soft_reset = 1'b0;
logic restart_state = 1'b0;
logic hs_clear = 1'b0;
logic measure_function_select = 1'b0;
logic [2:0] wake_enable = 3'h7;
logic [1:0] timer_wake_enable = 2'h1;
logic [11:0] hs_config = 12'h000;
logic [7:0] timer_b_config = 8'h00;
logic [2:0] wake_pin = 3'h0;
wcs_pkg::wcs_reg_req_t reg_req;
logic [7:0] reg_rdata;
logic [2:0] wake_pull_up, wake_pull_down, wake_level, wake_event;
logic [1:0] timer_out, timer_wake_event;
logic [3:0] hs_timer_drive, high_side_switch_output;
int errors = 0;
int n_checks = 0;
always #5 clk = ~clk;
////////////////////////////////////////
wcs_wake_cyclic #(.TICK_CYCLES(TICK), .FLT_LONG_CYCLES(2000)) i_wcs_wake_cyclic (
    .clk(clk), .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .soft_reset(soft_reset), .restart_state(restart_state), .hs_clear(hs_clear),
    .measure_function_select(measure_function_select), .wake_enable(wake_enable),
    .timer_wake_enable(timer_wake_enable), .timer_b_config(timer_b_config),
    .hs_config(hs_config),
    .wake_pin(wake_pin), .wake_pull_up(wake_pull_up), .wake_pull_down(wake_pull_down),
    .wake_level(wake_level), .wake_event(wake_event), .timer_out(timer_out),
    .timer_wake_event(timer_wake_event), .hs_timer_drive(hs_timer_drive),
    .high_side_switch_output(high_side_switch_output));
wcs_host i_wcs_host (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata));
////////////////////////////////////////
task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
        errors++;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
endtask : check

task automatic test_done;
    if (errors == 0 && n_checks > 0) begin
        $display("Result: passed");
    end else begin
        $display("Result: failed");
    end
    $finish;
endtask : test_done

task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
endtask : cyc

// Skips the first on-time, which the free-running tick leaves unaligned
task automatic cycle_len(input int t, output int hi, output int per);
    hi = 0;
    per = 0;
    cyc(1);
    for (int i = 0; i < 3000 && timer_out[t] === 1'b1; i++) cyc(1);
    while (timer_out[t] !== 1'b1 && per < 30000) begin
        cyc(1);
        per++;
    end
    while (timer_out[t] === 1'b1 && hi < 30000) begin
        cyc(1);
        hi++;
    end
    per += hi;
endtask : cycle_len
////////////////////////////////////////
task automatic t_regs;
    logic [7:0] d;
    logic [6:0] a [4] = '{wcs_pkg::ADDR_WAKE_PULL, wcs_pkg::ADDR_WAKE_FILTER,
        wcs_pkg::ADDR_TIMER_A, 7'h0a};
    logic [7:0] m [4] = '{wcs_pkg::MASK_WAKE, wcs_pkg::MASK_WAKE, wcs_pkg::MASK_TIMER, 8'h00};
    for (int i = 0; i < 4; i++) begin
        i_wcs_host.read_reg(a[i], d);
        check(16'(d), 16'h0000);
        i_wcs_host.write_reg(a[i], 8'hff);
        i_wcs_host.read_reg(a[i], d);
        check(16'(d), 16'(m[i]));
        i_wcs_host.write_reg(a[i], 8'h00);
    end
endtask : t_regs

task automatic t_pull;
    logic [1:0] c;
    for (int k = 0; k < 4; k++) begin
        c = 2'(k);
        i_wcs_host.write_reg(wcs_pkg::ADDR_WAKE_PULL, {2'h0, c, c, c});
        cyc(3);
        check(16'(wake_pull_up), (c == wcs_pkg::PULL_UP) ? 16'h0007 : 16'h0000);
        check(16'(wake_pull_down), (c == wcs_pkg::PULL_DOWN || c == wcs_pkg::PULL_AUTO)
            ? 16'h0007 : 16'h0000);
    end
endtask : t_pull

task automatic t_static;
    int i;
    i_wcs_host.write_reg(wcs_pkg::ADDR_WAKE_FILTER, 8'h00);
    measure_function_select = 1'b1;
    wake_pin = 3'h7;
    cyc(1000);
    wake_pin = 3'h0;
    cyc(1700);
    check(16'(wake_level), 16'h0000);
    wake_pin = 3'h7;
    for (i = 0; i < 1700 && wake_event[2] !== 1'b1; i++) cyc(1);
    check(16'(wake_event), 16'h0004);
    cyc(5);
    check(16'(wake_level), 16'h0007);
    i_wcs_host.write_reg(wcs_pkg::ADDR_WAKE_FILTER, 8'h01);
    wake_pin = 3'h0;
    cyc(1700);
    check(16'(wake_level), 16'h0001);
    cyc(400);
    check(16'(wake_level), 16'h0000);
    measure_function_select = 1'b0;
endtask : t_static

task automatic t_timer;
    int on_t [5] = '{1, 3, 10, 100, 200};
    int per_t [5] = '{100, 200, 500, 1000, 2000};
    logic [7:0] sc [4] = '{8'h60, 8'h00, 8'h70, 8'h17};
    logic [1:0] se [4] = '{2'h3, 2'h0, 2'h0, 2'h0};
    int h;
    int p;
    hs_config = {9'h000, wcs_pkg::HS_BY_TIMER_A};
    for (int i = 0; i < 5; i++) begin
        i_wcs_host.write_reg(wcs_pkg::ADDR_TIMER_A, {1'b0, 3'(i + 1), 1'b0, 3'(i)});
        cycle_len(0, h, p);
        check(16'(h), 16'(on_t[i] * TICK));
        check(16'(p), 16'(per_t[i] * TICK));
    end
    check(16'(hs_timer_drive), 16'h0001);
    for (int i = 0; i < 4; i++) begin
        i_wcs_host.write_reg(wcs_pkg::ADDR_TIMER_A, sc[i]);
        cyc(5);
        check(16'({timer_out[0], high_side_switch_output[0]}), 16'(se[i]));
    end
    hs_config = {6'h00, wcs_pkg::HS_BY_TIMER_B, wcs_pkg::HS_BY_TIMER_A};
    timer_b_config = 8'h10;
    cycle_len(1, h, p);
    check(16'(h), 16'(TICK));
    check(16'(p), 16'(100 * TICK));
    timer_b_config = 8'h60;
    cyc(5);
    check(16'({timer_out[1], high_side_switch_output[1], hs_timer_drive[1]}), 16'h0007);
    timer_b_config = 8'h00;
endtask : t_timer

task automatic t_cyclic;
    int i;
    logic [7:0] d;
    i_wcs_host.write_reg(wcs_pkg::ADDR_WAKE_FILTER, 8'h02);
    i_wcs_host.write_reg(wcs_pkg::ADDR_TIMER_A, 8'h52);
    wake_pin = 3'h1;
    cyc(1700);
    check(16'(wake_level), 16'h0000);
    for (i = 0; i < 400 && wake_level[0] !== 1'b1; i++) cyc(1);
    check(16'(wake_level), 16'h0001);
    for (i = 0; i < 5000 && timer_wake_event[0] !== 1'b1; i++) cyc(1);
    check(16'(timer_wake_event), 16'h0001);
    restart_state = 1'b1;
    hs_clear = 1'b1;
    cyc(1);
    hs_clear = 1'b0;
    i_wcs_host.read_reg(wcs_pkg::ADDR_TIMER_A, d);
    check(16'(d), 16'h0000);
    i_wcs_host.read_reg(wcs_pkg::ADDR_WAKE_FILTER, d);
    check(16'(d), 16'h0002);
    restart_state = 1'b0;
    soft_reset = 1'b1;
    cyc(1);
    soft_reset = 1'b0;
    i_wcs_host.read_reg(wcs_pkg::ADDR_WAKE_FILTER, d);
    check(16'(d), 16'h0000);
endtask : t_cyclic
////////////////////////////////////////
initial begin
    #800000;
    errors++;
    test_done();
end

initial begin
    repeat (3) @(posedge clk);
    #1;
    resetn = 1'b1;
    t_regs();
    t_pull();
    t_static();
    t_timer();
    t_cyclic();
    test_done();
end
endmodule : tb_wcs_wake_cyclic
